// ===== tesi_pkg.sv
// Constants and types for the terminal escape sequence interpreter
package tesi_pkg;
  localparam logic [7:0] CH_ESC = 8'h1b;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_LBR = 8'h5b;
  localparam logic [7:0] CH_QM = 8'h3f;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_BANG = 8'h21;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_BSL = 8'h5c;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_OFFSET = 8'h1f;
  localparam logic [7:0] CH_LO = 8'h20;
  localparam logic [7:0] CH_HI = 8'h7e;
  localparam logic [7:0] DEF_PARAM = 8'h01;
  localparam logic [7:0] FIN_TOP = 8'h40;
  localparam logic [7:0] PAR_MAX = 8'hff;
  localparam int FIFO_DEPTH = 16;
  localparam int MODE_W = 12;
  // Mode bit positions
  localparam int MB_NEWLINE = 0;
  localparam int MB_CURKEY = 1;
  localparam int MB_COMPAT = 2;
  localparam int MB_SCROLL = 3;
  localparam int MB_INVERT = 4;
  localparam int MB_WRAP = 5;
  localparam int MB_REPEAT = 6;
  localparam int MB_OVERWR = 7;
  localparam int MB_LBASIC = 8;
  localparam int MB_HBASIC = 9;
  localparam int MB_PKEYS = 10;
  localparam int MB_APRINT = 11;
  localparam logic [MODE_W-1:0] MODE_RESET = 12'h060;
  localparam logic [2:0] CS_UK = 3'h0;
  localparam logic [2:0] CS_US = 3'h1;
  localparam logic [2:0] CS_SOFT1 = 3'h2;
  localparam logic [2:0] CS_SOFT2 = 3'h3;
  localparam logic [2:0] CS_SOFT3 = 3'h4;
  localparam logic [2:0] CS_RESET = 3'h1;
  // Commands issued to the display engine
  typedef enum logic [4:0] {
    CMD_NONE = 5'h00, CMD_UP = 5'h01, CMD_DOWN = 5'h02,
    CMD_RIGHT = 5'h03, CMD_LEFT = 5'h04, CMD_HOME = 5'h05,
    CMD_GOTO = 5'h06, CMD_ERASE_EOS = 5'h07, CMD_ERASE_EOL = 5'h08,
    CMD_PRINT_ALL = 5'h09, CMD_PRINT_PART = 5'h0a, CMD_XHATCH = 5'h0b,
    CMD_SELFTEST = 5'h0c, CMD_SOFT_RESET = 5'h0d, CMD_ERASE_LINE = 5'h0e,
    CMD_ERASE_SCR = 5'h0f
  } tesi_cmd_type;
  typedef struct packed {
    tesi_cmd_type op;
    logic [7:0] arg_a;
    logic [7:0] arg_b;
  } tesi_action_type;
  // Reply kinds
  typedef enum logic [1:0] {
    RPL_CPR = 2'h0, RPL_OK = 2'h1, RPL_ID = 2'h2, RPL_COMPAT_ID = 2'h3
  } tesi_reply_type;
  typedef enum logic [1:0] {
    DCS_NONE = 2'h0, DCS_SETUP = 2'h1, DCS_KEYPAD = 2'h2, DCS_DISCARD = 2'h3
  } tesi_dcs_type;
  typedef enum logic [2:0] {
    ST_GROUND = 3'h0, ST_ESC = 3'h1, ST_CSI = 3'h2, ST_SUB = 3'h3,
    ST_DCS = 3'h4, ST_DCS_ESC = 3'h5, ST_YLINE = 3'h6, ST_YCOL = 3'h7
  } tesi_state_type;
endpackage

// ===== tesi_fifo.sv
// Parameterised valid/ready FIFO for incoming host characters
`timescale 1ns/1ps
module tesi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  logic full;
  logic empty;
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                (wr_ptr[AW] != rd_ptr[AW]);
  assign empty = (wr_ptr == rd_ptr);
  assign push = in_valid_in && !full && ce_in;
  assign pop = out_ready_in && !empty;
  // A frozen block refuses characters rather than losing them
  assign in_ready_out = !full && ce_in;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge mclk_in) begin
    if (ce_in && push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce_in) begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===== tesi_top.sv
// Escape sequence interpreter: parser, modes, commands and replies
`timescale 1ns/1ps
module tesi_top
  import tesi_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  input wire logic [7:0] rx_data_in,
  input wire logic linefeed_graphics_entry_in,
  input wire logic [7:0] cursor_line_in,
  input wire logic [7:0] cursor_col_in,
  input wire logic action_ready_in,
  output logic action_valid_out,
  output tesi_action_type action_out,
  output logic reply_valid_out,
  output tesi_reply_type reply_kind_out,
  output logic [7:0] reply_line_out,
  output logic [7:0] reply_col_out,
  output logic [1:0] indicator_out,
  output logic [2:0] primary_charset_out,
  output logic [2:0] secondary_charset_slot_out,
  output logic graphics_mode_out,
  output logic keypad_style_mode_out,
  output logic [MODE_W-1:0] mode_out,
  output logic [MODE_W-1:0] setup_mode_out,
  output logic [4:0] selftest_mask_out,
  output logic selftest_repeat_out,
  output tesi_dcs_type dcs_route_out,
  output logic dcs_valid_out,
  output logic [7:0] dcs_data_out
);
  tesi_state_type state;
  logic fifo_valid;
  logic [7:0] ch;
  logic take;
  logic [7:0] sub_lead;
  logic private_mark;
  logic bang_mark;
  logic [7:0] numeric_param;
  logic [7:0] first_param;
  logic [1:0] param_count;
  logic [7:0] line_param;
  logic is_digit;
  logic is_final;
  logic [7:0] eff;
  logic [7:0] digit_val;
  logic [7:0] acc_next;
  logic [15:0] acc_wide;
  logic [1:0] lamp_pend;
  logic [1:0] lamp_step;

  // Parser stalls while a command awaits the display engine
  assign take = fifo_valid && !(action_valid_out && !action_ready_in);

  tesi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .in_valid_in(rx_valid_in),
    .in_ready_out(rx_ready_out),
    .in_data_in(rx_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(take),
    .out_data_out(ch)
  );

  assign is_digit = (ch >= CH_0) && (ch <= CH_9);
  assign is_final = (ch >= FIN_TOP) && (ch <= CH_HI);
  assign digit_val = ch - CH_0;
  // Saturating decimal accumulation keeps huge values harmlessly unsupported
  assign acc_wide = (16'(numeric_param) * 16'h000a) + 16'(digit_val);
  assign acc_next = (acc_wide > 16'(PAR_MAX)) ? PAR_MAX : acc_wide[7:0];
  assign eff = (numeric_param == 8'h00) ? DEF_PARAM : numeric_param;
  // Lamp value once the current parameter is applied to the pending copy
  assign lamp_step = (numeric_param == 8'h00) ? 2'b00 :
                     (numeric_param == 8'h01) ? (lamp_pend | 2'b01) :
                     (numeric_param == 8'h02) ? (lamp_pend | 2'b10) :
                     lamp_pend;

  // Parser state
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state <= ST_GROUND;
      sub_lead <= 8'h00;
    end else if (ce_in && take) begin
      if (ch == CH_ESC && state != ST_DCS && state != ST_DCS_ESC) begin
        state <= ST_ESC;
      end else begin
        unique case (state)
          ST_GROUND: state <= ST_GROUND;
          ST_ESC: begin
            sub_lead <= ch;
            if (ch == CH_LBR && !mode_out[MB_COMPAT]) begin
              state <= ST_CSI;
            end else if (ch == 8'h50) begin
              state <= ST_SUB;
            end else if (ch == 8'h59 && mode_out[MB_COMPAT]) begin
              state <= ST_YLINE;
            end else if (!mode_out[MB_COMPAT] &&
                         (ch == 8'h28 || ch == 8'h29 || ch == CH_HASH)) begin
              state <= ST_SUB;
            end else begin
              state <= ST_GROUND;
            end
          end
          ST_CSI: state <= is_final ? ST_GROUND : ST_CSI;
          ST_SUB: begin
            if (sub_lead == 8'h50 && ch != 8'h70) begin
              state <= ST_DCS;
            end else begin
              state <= ST_GROUND;
            end
          end
          ST_DCS: state <= (ch == CH_ESC) ? ST_DCS_ESC : ST_DCS;
          ST_DCS_ESC: begin
            if (ch == CH_BSL) begin
              state <= ST_GROUND;
            end else if (ch == CH_ESC) begin
              state <= ST_DCS_ESC;
            end else begin
              state <= ST_DCS;
            end
          end
          ST_YLINE: state <= ST_YCOL;
          ST_YCOL: state <= ST_GROUND;
        endcase
      end
    end
  end

  // Control sequence parameters, split at each semicolon
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      numeric_param <= 8'h00;
      first_param <= 8'h00;
      param_count <= 2'h0;
      private_mark <= 1'b0;
      bang_mark <= 1'b0;
      line_param <= 8'h00;
    end else if (ce_in && take) begin
      if (state == ST_ESC) begin
        numeric_param <= 8'h00;
        param_count <= 2'h0;
        private_mark <= 1'b0;
        bang_mark <= 1'b0;
      end else if (state == ST_CSI) begin
        if (is_digit) begin
          numeric_param <= acc_next;
        end else if (ch == CH_SEMI) begin
          numeric_param <= 8'h00;
          if (param_count == 2'h0) begin
            first_param <= numeric_param;
          end
          if (param_count != 2'h3) begin
            param_count <= param_count + 2'h1;
          end
        end else if (ch == CH_QM) begin
          private_mark <= 1'b1;
        end else if (ch == CH_BANG) begin
          bang_mark <= 1'b1;
        end
      end else if (state == ST_YLINE) begin
        line_param <= ch - CH_OFFSET;
      end
    end
  end

  // Mode bits: live copy and stored setup copy
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      mode_out <= MODE_RESET;
      setup_mode_out <= MODE_RESET;
    end else if (ce_in && take) begin
      if (state == ST_ESC && ch == 8'h63) begin
        mode_out <= setup_mode_out;
      end else if (state == ST_ESC && ch == 8'h3c && mode_out[MB_COMPAT]) begin
        mode_out[MB_COMPAT] <= 1'b0;
        setup_mode_out[MB_COMPAT] <= 1'b0;
      end else if (state == ST_CSI && (ch == 8'h68 || ch == 8'h6c) &&
                   !bang_mark) begin
        // Only the last parameter acts; earlier ones are dropped
        if (!private_mark && numeric_param == 8'd20) begin
          mode_out[MB_NEWLINE] <= (ch == 8'h68);
          setup_mode_out[MB_NEWLINE] <= (ch == 8'h68);
        end else if (private_mark) begin
          unique case (numeric_param)
            8'd1: begin
              mode_out[MB_CURKEY] <= (ch == 8'h68);
              setup_mode_out[MB_CURKEY] <= (ch == 8'h68);
            end
            8'd2: begin
              if (ch == 8'h6c) begin
                mode_out[MB_COMPAT] <= 1'b1;
                setup_mode_out[MB_COMPAT] <= 1'b1;
              end
            end
            8'd4: begin
              mode_out[MB_SCROLL] <= (ch == 8'h68);
              setup_mode_out[MB_SCROLL] <= (ch == 8'h68);
            end
            8'd5: begin
              mode_out[MB_INVERT] <= (ch == 8'h68);
              setup_mode_out[MB_INVERT] <= (ch == 8'h68);
            end
            8'd7: begin
              mode_out[MB_WRAP] <= (ch == 8'h68);
              setup_mode_out[MB_WRAP] <= (ch == 8'h68);
            end
            8'd8: begin
              mode_out[MB_REPEAT] <= (ch == 8'h68);
              setup_mode_out[MB_REPEAT] <= (ch == 8'h68);
            end
            8'd20: begin
              mode_out[MB_OVERWR] <= (ch == 8'h68);
              setup_mode_out[MB_OVERWR] <= (ch == 8'h68);
            end
            8'd21: begin
              mode_out[MB_LBASIC] <= (ch == 8'h68);
              setup_mode_out[MB_LBASIC] <= (ch == 8'h68);
            end
            8'd22: begin
              mode_out[MB_HBASIC] <= (ch == 8'h68);
              setup_mode_out[MB_HBASIC] <= (ch == 8'h68);
            end
            8'd23: begin
              mode_out[MB_PKEYS] <= (ch == 8'h68);
              setup_mode_out[MB_PKEYS] <= (ch == 8'h68);
            end
            8'd24: begin
              mode_out[MB_APRINT] <= (ch == 8'h68);
              setup_mode_out[MB_APRINT] <= (ch == 8'h68);
            end
            default: mode_out <= mode_out;
          endcase
        end
      end
    end
  end

  // Lamps, character sets, keypad and graphics mode
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      indicator_out <= 2'b00;
      lamp_pend <= 2'b00;
      primary_charset_out <= CS_RESET;
      secondary_charset_slot_out <= CS_RESET;
      keypad_style_mode_out <= 1'b0;
      graphics_mode_out <= 1'b0;
    end else if (ce_in && take) begin
      if (ch == CH_ESC) begin
        graphics_mode_out <= 1'b0;
      end else if (state == ST_GROUND && ch == CH_LF &&
                   linefeed_graphics_entry_in) begin
        graphics_mode_out <= !graphics_mode_out;
      end
      if (state == ST_SUB && sub_lead == 8'h50 && ch == 8'h70) begin
        graphics_mode_out <= 1'b1;
      end
      if (state == ST_ESC && ch == 8'h3d) begin
        keypad_style_mode_out <= 1'b1;
      end
      if (state == ST_ESC && ch == 8'h3e) begin
        keypad_style_mode_out <= 1'b0;
      end
      if (state == ST_ESC && ch == 8'h63) begin
        indicator_out <= 2'b00;
        keypad_style_mode_out <= 1'b0;
      end
      // Parameters run in order on a copy; other finals leave lamps alone
      if (state == ST_ESC) begin
        lamp_pend <= indicator_out;
      end else if (state == ST_CSI && ch == CH_SEMI) begin
        lamp_pend <= lamp_step;
      end
      if (state == ST_CSI && !private_mark && !bang_mark && ch == 8'h71) begin
        indicator_out <= lamp_step;
      end
      if (state == ST_SUB && (sub_lead == 8'h28 || sub_lead == 8'h29)) begin
        logic [2:0] cs;
        logic ok;
        cs = CS_US;
        ok = 1'b1;
        unique case (ch)
          8'h41: cs = CS_UK;
          8'h42: cs = CS_US;
          8'h30: cs = CS_SOFT1;
          8'h31: cs = CS_SOFT2;
          8'h32: cs = CS_SOFT3;
          default: ok = 1'b0;
        endcase
        if (ok && sub_lead == 8'h28) begin
          primary_charset_out <= cs;
        end
        if (ok && sub_lead == 8'h29) begin
          secondary_charset_slot_out <= cs;
        end
      end
    end
  end

  // Self test selection accumulates per parameter after the first, whatever its value
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      selftest_mask_out <= 5'h00;
      selftest_repeat_out <= 1'b0;
    end else if (ce_in && take) begin
      if (state == ST_ESC) begin
        selftest_mask_out <= 5'h00;
        selftest_repeat_out <= 1'b0;
      end else if (state == ST_CSI && param_count != 2'h0 &&
                   (ch == CH_SEMI || ch == 8'h79)) begin
        if (numeric_param >= 8'd1 && numeric_param <= 8'd5) begin
          selftest_mask_out[3'(numeric_param - 8'd1)] <= 1'b1;
        end else if (numeric_param == 8'd9) begin
          selftest_repeat_out <= 1'b1;
        end
      end
    end
  end

  // Display engine commands
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      action_valid_out <= 1'b0;
      action_out <= '{op: CMD_NONE, arg_a: 8'h00, arg_b: 8'h00};
    end else if (ce_in) begin
      if (action_valid_out && action_ready_in) begin
        action_valid_out <= 1'b0;
      end
      if (take) begin
        tesi_action_type a;
        a = '{op: CMD_NONE, arg_a: 8'h00, arg_b: 8'h00};
        if (state == ST_ESC && ch != CH_ESC) begin
          if (ch == 8'h63) begin
            a.op = CMD_SOFT_RESET;
          end else if (mode_out[MB_COMPAT]) begin
            unique case (ch)
              8'h41: a.op = CMD_UP;
              8'h42: a.op = CMD_DOWN;
              8'h43: a.op = CMD_RIGHT;
              8'h44: a.op = CMD_LEFT;
              8'h48: a.op = CMD_HOME;
              8'h4a: a.op = CMD_ERASE_EOS;
              8'h4b: a.op = CMD_ERASE_EOL;
              default: a.op = CMD_NONE;
            endcase
            a.arg_a = DEF_PARAM;
          end
        end else if (state == ST_SUB && sub_lead == CH_HASH) begin
          if (ch == 8'h37) begin
            a.op = CMD_PRINT_ALL;
          end else if (ch == 8'h38) begin
            a.op = CMD_XHATCH;
          end
        end else if (state == ST_YCOL) begin
          a = '{op: CMD_GOTO, arg_a: line_param, arg_b: 8'(ch - CH_OFFSET)};
        end else if (state == ST_CSI && !private_mark && is_final) begin
          unique case (ch)
            8'h41: a = '{op: CMD_UP, arg_a: eff, arg_b: 8'h00};
            8'h42: a = '{op: CMD_DOWN, arg_a: eff, arg_b: 8'h00};
            8'h43: a = '{op: CMD_RIGHT, arg_a: eff, arg_b: 8'h00};
            8'h44: a = '{op: CMD_LEFT, arg_a: eff, arg_b: 8'h00};
            8'h71: begin
              if (bang_mark) begin
                a = '{op: CMD_PRINT_PART, arg_a: first_param,
                      arg_b: numeric_param};
              end
            end
            8'h79: begin
              if (first_param == 8'd3) begin
                a.op = CMD_SELFTEST;
              end
            end
            default: a.op = CMD_NONE;
          endcase
        end
        if (a.op != CMD_NONE) begin
          action_out <= a;
          action_valid_out <= 1'b1;
        end
      end
    end
  end

  // Replies to the host, one cycle pulse
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      reply_valid_out <= 1'b0;
      reply_kind_out <= RPL_OK;
      reply_line_out <= 8'h00;
      reply_col_out <= 8'h00;
    end else if (ce_in) begin
      reply_valid_out <= 1'b0;
      if (take && state == ST_CSI && !private_mark && ch == 8'h6e) begin
        if (numeric_param == 8'd6) begin
          reply_valid_out <= 1'b1;
          reply_kind_out <= RPL_CPR;
          reply_line_out <= cursor_line_in;
          reply_col_out <= cursor_col_in;
        end else if (numeric_param == 8'd5) begin
          reply_valid_out <= 1'b1;
          reply_kind_out <= RPL_OK;
        end
      end else if (take && state == ST_CSI && !private_mark && ch == 8'h63 &&
                   numeric_param == 8'h00 && param_count == 2'h0) begin
        reply_valid_out <= 1'b1;
        reply_kind_out <= RPL_ID;
      end else if (take && state == ST_ESC && ch == 8'h5a) begin
        reply_valid_out <= 1'b1;
        reply_kind_out <= mode_out[MB_COMPAT] ? RPL_COMPAT_ID : RPL_ID;
      end
    end
  end

  // Device control string routing
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      dcs_route_out <= DCS_NONE;
      dcs_valid_out <= 1'b0;
      dcs_data_out <= 8'h00;
    end else if (ce_in) begin
      dcs_valid_out <= 1'b0;
      if (take && state == ST_SUB && sub_lead == 8'h50) begin
        unique case (ch)
          8'h72: dcs_route_out <= DCS_SETUP;
          8'h71: dcs_route_out <= DCS_DISCARD;
          8'h70: dcs_route_out <= DCS_NONE;
          default: dcs_route_out <= DCS_KEYPAD;
        endcase
      end else if (take && state == ST_DCS && ch != CH_ESC) begin
        dcs_valid_out <= (dcs_route_out != DCS_DISCARD);
        dcs_data_out <= ch;
      end else if (take && state == ST_DCS_ESC && ch == CH_BSL) begin
        dcs_route_out <= DCS_NONE;
      end
    end
  end
endmodule

// ===== tesi_props.sv
// Port checker for the escape sequence interpreter
`timescale 1ns/1ps
module tesi_props
  import tesi_pkg::*;
(
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic rx_ready_out,
  input wire logic action_ready_in,
  input wire logic action_valid_out,
  input wire tesi_action_type action_out,
  input wire logic reply_valid_out,
  input wire logic dcs_valid_out,
  input wire tesi_dcs_type dcs_route_out,
  input wire logic [1:0] indicator_out,
  input wire logic [2:0] primary_charset_out,
  input wire logic [2:0] secondary_charset_slot_out,
  input wire logic [MODE_W-1:0] mode_out,
  input wire logic [MODE_W-1:0] setup_mode_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_reply_pulse: assert property (reply_valid_out |=> !reply_valid_out)
    else $error("reply held longer than one cycle");
  a_action_held: assert property (action_valid_out && !action_ready_in
    |=> action_valid_out && $stable(action_out))
    else $error("action dropped or changed before acceptance");
  a_setup_follow: assert property ($changed(mode_out)
    |-> setup_mode_out == mode_out)
    else $error("stored setup copy missed a mode change");
  a_charset_legal: assert property (primary_charset_out <= CS_SOFT3
    && secondary_charset_slot_out <= CS_SOFT3)
    else $error("character set code out of range");
  a_dcs_routed: assert property (dcs_valid_out
    |-> dcs_route_out inside {DCS_SETUP, DCS_KEYPAD})
    else $error("string data passed on for a discarded route");
  a_action_known: assert property (action_valid_out
    |-> action_out.op != CMD_NONE)
    else $error("empty action offered");
  // Own disable so the reset edge itself is judged
  a_reset_clear: assert property (disable iff (1'b0) reset_in |=>
    !reply_valid_out && !action_valid_out && indicator_out == 2'h0
    && mode_out == MODE_RESET && primary_charset_out == CS_RESET)
    else $error("reset state wrong");
  a_full_stall: assert property (!rx_ready_out && action_valid_out
    && !action_ready_in |=> !rx_ready_out)
    else $error("full buffer drained while parser stalled");
  c_reply: cover property (reply_valid_out);
  c_dcs: cover property (dcs_valid_out);
  c_full: cover property (!rx_ready_out);
endmodule
bind tesi_top tesi_props i_props (.mclk_in, .reset_in, .rx_ready_out,
  .action_ready_in, .action_valid_out, .action_out, .reply_valid_out,
  .dcs_valid_out, .dcs_route_out, .indicator_out, .primary_charset_out,
  .secondary_charset_slot_out, .mode_out, .setup_mode_out);

// ===== tesi_host_model.sv
// Host model: offers characters one by one on valid/ready
`timescale 1ns/1ps
module tesi_host_model (
  input wire logic mclk_in,
  input wire logic ready_in,
  output logic valid_out = 1'b0,
  output logic [7:0] data_out = 8'h00
);
  // Characters leave in the order given; gives up on a stuck buffer
  task automatic send(input logic [7:0] c);
    logic ok;
    int n;
    n = 0;
    valid_out = 1'b1;
    data_out = c;
    do begin
      ok = ready_in;
      @(posedge mclk_in);
      #1;
      n++;
    end while (!ok && n < 40);
  endtask
  // Released line shows the inverse so a stale value cannot match
  task automatic stop();
    valid_out = 1'b0;
    data_out = ~data_out;
  endtask
endmodule

// ===== test_terminal_escape_sequence_interpreter.sv
// Self-checking bench for the escape sequence interpreter
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  bad_count++; $display("BAD %0t %h %h", $time, (a), (b)); end end
module test_terminal_escape_sequence_interpreter;
  import tesi_pkg::*;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic lf_gfx = 1'b0;
  logic act_rdy = 1'b1;
  logic rx_v, rx_rdy, act_v, rp_v, gfx, kp, st_rep, dcs_v;
  logic [7:0] rx_d, rp_line, rp_col, dcs_d, got_line, got_col, got_dcs;
  tesi_action_type act, got_act;
  tesi_reply_type rp_kind, got_kind;
  logic [1:0] lamps;
  logic [2:0] cs0, cs1;
  logic [MODE_W-1:0] mode, setup;
  logic [4:0] st_mask;
  int bad_count = 0;
  int checks_done = 0;
  int dcs_n = 0;
  always #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    if (rp_v) begin
      got_kind <= rp_kind;
      got_line <= rp_line;
      got_col <= rp_col;
    end
    if (act_v && act_rdy)
      got_act <= act;
    if (dcs_v) begin
      dcs_n <= dcs_n + 1;
      got_dcs <= dcs_d;
    end
  end
  tesi_host_model i_host (.mclk_in, .ready_in(rx_rdy), .valid_out(rx_v),
    .data_out(rx_d));
  tesi_top i_dut (.mclk_in, .reset_in, .ce_in(1'b1), .rx_valid_in(rx_v),
    .rx_ready_out(rx_rdy), .rx_data_in(rx_d),
    .linefeed_graphics_entry_in(lf_gfx), .cursor_line_in(8'h0c),
    .cursor_col_in(8'h22), .action_ready_in(act_rdy),
    .action_valid_out(act_v), .action_out(act), .reply_valid_out(rp_v),
    .reply_kind_out(rp_kind), .reply_line_out(rp_line),
    .reply_col_out(rp_col), .indicator_out(lamps),
    .primary_charset_out(cs0), .secondary_charset_slot_out(cs1),
    .graphics_mode_out(gfx), .keypad_style_mode_out(kp), .mode_out(mode),
    .setup_mode_out(setup), .selftest_mask_out(st_mask),
    .selftest_repeat_out(st_rep), .dcs_route_out(), .dcs_valid_out(dcs_v),
    .dcs_data_out(dcs_d));
  task automatic tx(input string s);
    foreach (s[i]) i_host.send(s[i]);
    i_host.stop();
    repeat (6) @(posedge mclk_in);
    #1;
  endtask
  task automatic t_lamps_sets();
    string s;
    string sets = "AB012";
    `CHK(mode, MODE_RESET)
    tx("\033[1q");
    `CHK(lamps, 2'h1)
    tx("\033[0;2q");
    `CHK(lamps, 2'h2)
    tx("\033[q");
    `CHK(lamps, 2'h0)
    for (int i = 0; i < 5; i++) begin
      s = "\033(A";
      s.putc(2, sets[i]);
      tx(s);
      `CHK(cs0, CS_UK + 3'(i))
      s.putc(1, ")");
      tx(s);
      `CHK(cs1, CS_UK + 3'(i))
    end
    tx("\033(Z");
    `CHK(cs0, CS_SOFT3)
  endtask
  task automatic t_modes();
    int num[10] = '{1, 4, 5, 7, 8, 20, 21, 22, 23, 24};
    int b;
    string s;
    tx("\033[20h");
    `CHK(mode[MB_NEWLINE], 1'b1)
    for (int i = 0; i < 10; i++) begin
      b = (i == 0) ? MB_CURKEY : i + 2;
      s = $sformatf("\033[?%0dh", num[i]);
      tx(s);
      `CHK(mode[b], 1'b1)
      `CHK(setup[b], 1'b1)
      s.putc(s.len() - 1, "l");
      tx(s);
      `CHK(mode[b], 1'b0)
    end
    tx("\033[?2h\033=");
    `CHK(mode[MB_COMPAT], 1'b0)
    `CHK(kp, 1'b1)
    tx("\033>\033Pp");
    `CHK(kp, 1'b0)
    `CHK(gfx, 1'b1)
    tx("\033\\");
    `CHK(gfx, 1'b0)
    lf_gfx = 1'b1;
    tx("\n");
    `CHK(gfx, 1'b1)
    tx("\n");
    `CHK(gfx, 1'b0)
  endtask
  task automatic t_reports();
    tesi_cmd_type ops[7] = '{CMD_UP, CMD_DOWN, CMD_RIGHT, CMD_LEFT,
      CMD_HOME, CMD_ERASE_EOS, CMD_ERASE_EOL};
    string s;
    string keys = "ABCDHJK";
    tx("\033[6n");
    `CHK(got_kind, RPL_CPR)
    `CHK({got_line, got_col}, 16'h0c22)
    tx("\033[5n");
    `CHK(got_kind, RPL_OK)
    tx("\033[0c");
    `CHK(got_kind, RPL_ID)
    tx("\033[?2l\033Z");
    `CHK(got_kind, RPL_COMPAT_ID)
    for (int i = 0; i < 7; i++) begin
      s = "\033A";
      s.putc(1, keys[i]);
      tx(s);
      `CHK(got_act.op, ops[i])
    end
    tx("\033Y%(");
    `CHK(got_act.op, CMD_GOTO)
    `CHK(got_act.arg_a, 8'h25 - CH_OFFSET)
    `CHK(got_act.arg_b, 8'h28 - CH_OFFSET)
    tx("\033<\033Z");
    `CHK(got_kind, RPL_ID)
  endtask
  task automatic t_print();
    int n;
    tx("\033[0B");
    `CHK(got_act.arg_a, DEF_PARAM)
    tx("\033[3;5!q");
    `CHK(got_act, {CMD_PRINT_PART, 8'h03, 8'h05})
    tx("\033#8");
    `CHK(got_act.op, CMD_XHATCH)
    tx("\033[3;2;5;9y");
    `CHK({st_mask[4], st_mask[1], st_rep}, 3'h7)
    `CHK(lamps, 2'h0)
    tx("\033[1q\033[?7l\033c");
    `CHK({lamps, mode[MB_WRAP]}, 3'h0)
    n = dcs_n;
    tx("\033Prab\033\\\033Pqxy\033\\");
    `CHK(dcs_n - n, 2)
    `CHK(got_dcs, 8'h62)
    act_rdy = 1'b0;
    tx("\033#7");
    for (int i = 0; i < 17; i++) i_host.send("a");
    `CHK({rx_rdy, act_v, act.op}, {2'h1, CMD_PRINT_ALL})
    i_host.stop();
    act_rdy = 1'b1;
    repeat (30) @(posedge mclk_in);
    #1;
    `CHK({rx_rdy, act_v}, 2'h2)
  endtask
  task automatic results();
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk_in);
    #1;
    reset_in = 1'b0;
    t_lamps_sets();
    t_modes();
    t_reports();
    t_print();
    results();
  end
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule
